// *** ptp_time_pkg.sv ***
// constants for the precision-time clock core
package ptp_time_pkg;

	// register byte offsets
	localparam logic [11:0] OFS_CMD        = 12'h100;
	localparam logic [11:0] OFS_GPIO_CLR   = 12'h104;
	localparam logic [11:0] OFS_IRQ_STATUS = 12'h108;
	localparam logic [11:0] OFS_IRQ_ENABLE = 12'h10C;
	localparam logic [11:0] OFS_SEC        = 12'h110;
	localparam logic [11:0] OFS_NS         = 12'h114;
	localparam logic [11:0] OFS_SUBNS      = 12'h118;
	localparam logic [11:0] OFS_RATE       = 12'h11C;
	localparam logic [11:0] OFS_TGT_A_SEC  = 12'h12C;
	localparam logic [11:0] OFS_TGT_A_NS   = 12'h130;
	localparam logic [11:0] OFS_TGT_B_SEC  = 12'h13C;
	localparam logic [11:0] OFS_TGT_B_NS   = 12'h140;
	localparam logic [11:0] OFS_SYS_STATUS = 12'h180;
	localparam logic [11:0] OFS_SYS_ENABLE = 12'h184;

	// command bits, self clearing
	localparam int CMD_READ_BIT = 0;
	localparam int CMD_LOAD_BIT = 1;

	// interrupt status and enable layout
	localparam int TIMER_A_BIT = 0;
	localparam int TIMER_B_BIT = 1;
	localparam int RX_LSB      = 8;
	localparam int TX_LSB      = 12;
	localparam int RISE_LSB    = 16;
	localparam int FALL_LSB    = 24;
	localparam logic [31:0] IRQ_MASK = 32'hFFFF_7703;

	// gpio clear configuration layout
	localparam int GCLR_A_SEL_LSB = 0;
	localparam int GCLR_A_FALL    = 3;
	localparam int GCLR_A_EN      = 4;
	localparam int GCLR_B_SEL_LSB = 8;
	localparam int GCLR_B_FALL    = 11;
	localparam int GCLR_B_EN      = 12;
	localparam logic [31:0] GCLR_MASK = 32'h0000_1F1F;

	// rate trim layout
	localparam int RATE_DIR_BIT = 31;

	// reset values
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
	localparam logic [29:0] RESET_NS   = 30'h0000_0000;

	// clock steps in ns
	localparam logic [29:0] STEP_NOMINAL = 30'h0000_000A;
	localparam logic [29:0] STEP_SLOW    = 30'h0000_0009;
	localparam logic [29:0] STEP_FAST    = 30'h0000_000B;
	localparam logic [29:0] NS_PER_SEC   = 30'h3B9A_CA00;

	// gpio qualification time
	localparam int CLK_PERIOD_NS      = 100;
	localparam int GPIO_MIN_ACTIVE_NS = 40;
	localparam int GPIO_MIN_CYC_RAW   = GPIO_MIN_ACTIVE_NS / CLK_PERIOD_NS + 1;
	localparam int GPIO_MIN_CYC       = (GPIO_MIN_CYC_RAW < 1) ? 1 : GPIO_MIN_CYC_RAW;
	localparam int GPIO_CNT_W         = 4;
	localparam logic [GPIO_CNT_W-1:0] GPIO_CNT_ZERO = 4'h0;

endpackage

// *** ptp_clock_core_regs.sv ***
// precision-time clock core: time value, rate trim, compare timers, interrupts
module ptp_clock_core_regs #(
	parameter int GPIO_N = 8,
	parameter int PORT_N = 3
) (
	// clock and reset
	input  wire logic              clk_sys,
	input  wire logic              sys_rst,
	// register port
	input  wire logic [11:0]       reg_addr,
	input  wire logic [31:0]       reg_wr_data,
	input  wire logic              reg_wr_en,
	input  wire logic              reg_rd_en,
	output logic      [31:0]       reg_rd_data,
	// event sources
	input  wire logic [GPIO_N-1:0] gpio_in,
	input  wire logic [PORT_N-1:0] egress_stamp_event,
	input  wire logic [PORT_N-1:0] ingress_stamp_event,
	// time and interrupt outputs
	output logic      [31:0]       time_seconds_out,
	output logic      [29:0]       time_nanoseconds_out,
	output logic                   time_unit_summary_event,
	output logic                   irq_out
);

	localparam int GPIO_CNT_W = ptp_time_pkg::GPIO_CNT_W;

	typedef struct packed {
		logic [GPIO_N-1:0]                 sync1;
		logic [GPIO_N-1:0]                 sync2;
		logic [GPIO_N-1:0]                 sync3;
		logic [GPIO_N-1:0]                 filt;
		logic [GPIO_N-1:0][GPIO_CNT_W-1:0] qual_cnt;
		logic [31:0]                       sec;
		logic [29:0]                       ns;
		logic [31:0]                       subns;
		logic [31:0]                       sh_sec;
		logic [29:0]                       sh_ns;
		logic [31:0]                       sh_subns;
		logic                              rate_dir;
		logic [29:0]                       rate_amt;
		logic [31:0]                       status;
		logic [31:0]                       enable;
		logic [31:0]                       gclr;
		logic [31:0]                       tgt_a_sec;
		logic [29:0]                       tgt_a_ns;
		logic [31:0]                       tgt_b_sec;
		logic [29:0]                       tgt_b_ns;
		logic [1:0]                        ge_prev;
		logic                              glob_en;
		logic [31:0]                       rd_data;
	} state_s;

	state_s st_reg;
	state_s st_next;

	logic [GPIO_N-1:0] agree;
	logic [GPIO_N-1:0] rise_ev;
	logic [GPIO_N-1:0] fall_ev;
	logic [32:0]       sub_sum;
	logic [29:0]       step;
	logic [30:0]       ns_sum;
	logic [30:0]       load_ns;
	logic              ge_a;
	logic              ge_b;
	logic [1:0]        timer_set;
	logic [1:0]        gpio_clr;
	logic [31:0]       set_bits;
	logic [31:0]       clr_bits;
	logic              summary;
	logic [2:0]        sel_a;
	logic [2:0]        sel_b;
	logic              do_load;
	logic              do_read;

	always_comb begin
		st_next = st_reg;

		// gpio: three-stage synchroniser, then qualification
		st_next.sync1 = gpio_in;
		st_next.sync2 = st_reg.sync1;
		st_next.sync3 = st_reg.sync2;
		agree = ~(st_reg.sync2 ^ st_reg.sync3);
		for (int i = 0; i < GPIO_N; i++) begin
			if (agree[i] && (st_reg.sync3[i] != st_reg.filt[i])) begin
				// level must hold over the minimum active time
				if (int'(st_reg.qual_cnt[i]) + 1 >= ptp_time_pkg::GPIO_MIN_CYC) begin
					st_next.filt[i]     = st_reg.sync3[i];
					st_next.qual_cnt[i] = ptp_time_pkg::GPIO_CNT_ZERO;
				end else begin
					st_next.qual_cnt[i] = st_reg.qual_cnt[i] + GPIO_CNT_W'(1);
				end
			end else begin
				st_next.qual_cnt[i] = ptp_time_pkg::GPIO_CNT_ZERO;
			end
		end
		rise_ev = st_next.filt & ~st_reg.filt;
		fall_ev = ~st_next.filt & st_reg.filt;

		// time advance
		sub_sum = {1'b0, st_reg.subns} + {3'b000, st_reg.rate_amt};
		if (sub_sum[32]) begin
			step = st_reg.rate_dir ? ptp_time_pkg::STEP_FAST : ptp_time_pkg::STEP_SLOW;
		end else begin
			step = ptp_time_pkg::STEP_NOMINAL;
		end
		ns_sum = {1'b0, st_reg.ns} + {1'b0, step};
		st_next.subns = sub_sum[31:0];
		if (ns_sum >= {1'b0, ptp_time_pkg::NS_PER_SEC}) begin
			st_next.ns  = 30'(ns_sum - {1'b0, ptp_time_pkg::NS_PER_SEC});
			st_next.sec = st_reg.sec + 32'h0000_0001;
		end else begin
			st_next.ns  = ns_sum[29:0];
		end

		// compare timers, edge of at-or-past
		ge_a = {st_reg.sec, st_reg.ns} >= {st_reg.tgt_a_sec, st_reg.tgt_a_ns};
		ge_b = {st_reg.sec, st_reg.ns} >= {st_reg.tgt_b_sec, st_reg.tgt_b_ns};
		st_next.ge_prev = {ge_b, ge_a};
		timer_set[0] = ge_a && !st_reg.ge_prev[0];
		timer_set[1] = ge_b && !st_reg.ge_prev[1];

		// gpio clear of timer flags
		sel_a = st_reg.gclr[ptp_time_pkg::GCLR_A_SEL_LSB +: 3];
		sel_b = st_reg.gclr[ptp_time_pkg::GCLR_B_SEL_LSB +: 3];
		gpio_clr[0] = st_reg.gclr[ptp_time_pkg::GCLR_A_EN] &&
			(st_reg.gclr[ptp_time_pkg::GCLR_A_FALL] ? fall_ev[sel_a] : rise_ev[sel_a]);
		gpio_clr[1] = st_reg.gclr[ptp_time_pkg::GCLR_B_EN] &&
			(st_reg.gclr[ptp_time_pkg::GCLR_B_FALL] ? fall_ev[sel_b] : rise_ev[sel_b]);

		// status sources, independent of enables
		set_bits = ptp_time_pkg::RESET_WORD;
		set_bits[ptp_time_pkg::TIMER_A_BIT] = timer_set[0];
		set_bits[ptp_time_pkg::TIMER_B_BIT] = timer_set[1];
		set_bits[ptp_time_pkg::RX_LSB +: PORT_N] = ingress_stamp_event;
		set_bits[ptp_time_pkg::TX_LSB +: PORT_N] = egress_stamp_event;
		set_bits[ptp_time_pkg::RISE_LSB +: GPIO_N] = rise_ev;
		set_bits[ptp_time_pkg::FALL_LSB +: GPIO_N] = fall_ev;

		clr_bits = ptp_time_pkg::RESET_WORD;
		clr_bits[ptp_time_pkg::TIMER_A_BIT] = gpio_clr[0];
		clr_bits[ptp_time_pkg::TIMER_B_BIT] = gpio_clr[1];
		if (reg_wr_en && reg_addr == ptp_time_pkg::OFS_IRQ_STATUS) begin
			clr_bits = clr_bits | reg_wr_data;
		end

		// sticky flags, set wins over clear
		st_next.status = ((st_reg.status & ~clr_bits) | set_bits) & ptp_time_pkg::IRQ_MASK;

		// register writes
		do_load = 1'b0;
		do_read = 1'b0;
		if (reg_wr_en) begin
			if (reg_addr == ptp_time_pkg::OFS_CMD) begin
				do_read = reg_wr_data[ptp_time_pkg::CMD_READ_BIT];
				do_load = reg_wr_data[ptp_time_pkg::CMD_LOAD_BIT];
			end else if (reg_addr == ptp_time_pkg::OFS_GPIO_CLR) begin
				st_next.gclr = reg_wr_data & ptp_time_pkg::GCLR_MASK;
			end else if (reg_addr == ptp_time_pkg::OFS_IRQ_ENABLE) begin
				st_next.enable = reg_wr_data & ptp_time_pkg::IRQ_MASK;
			end else if (reg_addr == ptp_time_pkg::OFS_SEC) begin
				st_next.sh_sec = reg_wr_data;
			end else if (reg_addr == ptp_time_pkg::OFS_NS) begin
				st_next.sh_ns = reg_wr_data[29:0];
			end else if (reg_addr == ptp_time_pkg::OFS_SUBNS) begin
				st_next.sh_subns = reg_wr_data;
			end else if (reg_addr == ptp_time_pkg::OFS_RATE) begin
				st_next.rate_dir = reg_wr_data[ptp_time_pkg::RATE_DIR_BIT];
				st_next.rate_amt = reg_wr_data[29:0];
			end else if (reg_addr == ptp_time_pkg::OFS_TGT_A_SEC) begin
				st_next.tgt_a_sec = reg_wr_data;
			end else if (reg_addr == ptp_time_pkg::OFS_TGT_A_NS) begin
				st_next.tgt_a_ns = reg_wr_data[29:0];
			end else if (reg_addr == ptp_time_pkg::OFS_TGT_B_SEC) begin
				st_next.tgt_b_sec = reg_wr_data;
			end else if (reg_addr == ptp_time_pkg::OFS_TGT_B_NS) begin
				st_next.tgt_b_ns = reg_wr_data[29:0];
			end else if (reg_addr == ptp_time_pkg::OFS_SYS_ENABLE) begin
				st_next.glob_en = reg_wr_data[0];
			end
		end

		// snapshot of the time before this cycle's load
		if (do_read) begin
			st_next.sh_sec   = st_reg.sec;
			st_next.sh_ns    = st_reg.ns;
			st_next.sh_subns = st_reg.subns;
		end
		load_ns = {1'b0, st_reg.sh_ns};
		if (do_load) begin
			st_next.subns = st_reg.sh_subns;
			if (load_ns >= {1'b0, ptp_time_pkg::NS_PER_SEC}) begin
				st_next.ns  = 30'(load_ns - {1'b0, ptp_time_pkg::NS_PER_SEC});
				st_next.sec = st_reg.sh_sec + 32'h0000_0001;
			end else begin
				st_next.ns  = st_reg.sh_ns;
				st_next.sec = st_reg.sh_sec;
			end
		end

		// summary event from enabled flags
		summary = |(st_reg.status & st_reg.enable);

		// register reads, data one cycle later
		st_next.rd_data = ptp_time_pkg::RESET_WORD;
		if (reg_rd_en) begin
			if (reg_addr == ptp_time_pkg::OFS_GPIO_CLR) begin
				st_next.rd_data = st_reg.gclr;
			end else if (reg_addr == ptp_time_pkg::OFS_IRQ_STATUS) begin
				st_next.rd_data = st_reg.status;
			end else if (reg_addr == ptp_time_pkg::OFS_IRQ_ENABLE) begin
				st_next.rd_data = st_reg.enable;
			end else if (reg_addr == ptp_time_pkg::OFS_SEC) begin
				st_next.rd_data = st_reg.sh_sec;
			end else if (reg_addr == ptp_time_pkg::OFS_NS) begin
				st_next.rd_data = {2'b00, st_reg.sh_ns};
			end else if (reg_addr == ptp_time_pkg::OFS_SUBNS) begin
				st_next.rd_data = st_reg.sh_subns;
			end else if (reg_addr == ptp_time_pkg::OFS_RATE) begin
				st_next.rd_data = {st_reg.rate_dir, 1'b0, st_reg.rate_amt};
			end else if (reg_addr == ptp_time_pkg::OFS_TGT_A_SEC) begin
				st_next.rd_data = st_reg.tgt_a_sec;
			end else if (reg_addr == ptp_time_pkg::OFS_TGT_A_NS) begin
				st_next.rd_data = {2'b00, st_reg.tgt_a_ns};
			end else if (reg_addr == ptp_time_pkg::OFS_TGT_B_SEC) begin
				st_next.rd_data = st_reg.tgt_b_sec;
			end else if (reg_addr == ptp_time_pkg::OFS_TGT_B_NS) begin
				st_next.rd_data = {2'b00, st_reg.tgt_b_ns};
			end else if (reg_addr == ptp_time_pkg::OFS_SYS_STATUS) begin
				st_next.rd_data = {31'h0000_0000, summary};
			end else if (reg_addr == ptp_time_pkg::OFS_SYS_ENABLE) begin
				st_next.rd_data = {31'h0000_0000, st_reg.glob_en};
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign reg_rd_data             = st_reg.rd_data;
	assign time_seconds_out        = st_reg.sec;
	assign time_nanoseconds_out    = st_reg.ns;
	assign time_unit_summary_event = |(st_reg.status & st_reg.enable);
	assign irq_out                 = time_unit_summary_event & st_reg.glob_en;

endmodule

// *** ptp_clock_core_regs_chk.sv ***
// concurrent checks on the precision-time clock core ports
module ptp_clock_core_regs_chk #(
	parameter int GPIO_N = 8,
	parameter int PORT_N = 3
) (
	// clock, reset and register port
	input wire logic              clk_sys,
	input wire logic              sys_rst,
	input wire logic [11:0]       reg_addr,
	input wire logic [31:0]       reg_wr_data,
	input wire logic              reg_wr_en,
	input wire logic              reg_rd_en,
	input wire logic [31:0]       reg_rd_data,
	// events and time outputs
	input wire logic [GPIO_N-1:0] gpio_in,
	input wire logic [PORT_N-1:0] egress_stamp_event,
	input wire logic [PORT_N-1:0] ingress_stamp_event,
	input wire logic [31:0]       time_seconds_out,
	input wire logic [29:0]       time_nanoseconds_out,
	input wire logic              time_unit_summary_event,
	input wire logic              irq_out
);
	logic [31:0] en_reg;
	logic        glb_reg;

	// shadow of the enable words as the core keeps them, masked by IRQ_MASK and bit 0
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			en_reg  <= 32'h0000_0000;
			glb_reg <= 1'b0;
		end else if (reg_wr_en && reg_addr == ptp_time_pkg::OFS_IRQ_ENABLE) begin
			en_reg <= reg_wr_data & ptp_time_pkg::IRQ_MASK;
		end else if (reg_wr_en && reg_addr == ptp_time_pkg::OFS_SYS_ENABLE) begin
			glb_reg <= reg_wr_data[0];
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	sequence no_load;
		!(reg_wr_en && reg_addr == ptp_time_pkg::OFS_CMD);
	endsequence

	reset_zero_a: assert property ($past(sys_rst) |-> time_seconds_out == 32'h0000_0000
		&& time_nanoseconds_out == 30'h0000_0000) else $error("time not zero after reset");
	ns_step_a: assert property (no_load ##0 time_nanoseconds_out < 30'h3B9A_C9F5 |=>
		(time_nanoseconds_out - $past(time_nanoseconds_out)) inside {30'd9, 30'd10, 30'd11})
		else $error("bad nanosecond step");
	sec_carry_a: assert property (no_load ##1 $changed(time_seconds_out) |->
		time_seconds_out == $past(time_seconds_out) + 32'h1 && time_nanoseconds_out < 30'd11)
		else $error("bad seconds carry");
	ns_range_a: assert property (time_nanoseconds_out < ptp_time_pkg::NS_PER_SEC)
		else $error("nanoseconds out of range");
	irq_gate_a: assert property (irq_out |-> time_unit_summary_event && (glb_reg || $past(glb_reg)))
		else $error("interrupt without summary and global enable");
	summary_gate_a: assert property (time_unit_summary_event |-> en_reg != 0 || $past(en_reg) != 0)
		else $error("summary without enable");
	stamp_summary_a: assert property (((egress_stamp_event & en_reg[14:12])
		| (ingress_stamp_event & en_reg[10:8])) != 0 |-> ##[1:3] time_unit_summary_event)
		else $error("enabled stamp event lost");
	enable_read_a: assert property (reg_rd_en && reg_addr == ptp_time_pkg::OFS_IRQ_ENABLE |=>
		reg_rd_data == $past(en_reg)) else $error("enable readback wrong");
	irq_match_a: assert property (irq_out == (time_unit_summary_event && glb_reg))
		else $error("interrupt differs from summary and global enable");
	rd_idle_a: assert property (!reg_rd_en |=> reg_rd_data == 32'h0000_0000)
		else $error("read data not idle");
endmodule

bind ptp_clock_core_regs ptp_clock_core_regs_chk #(.GPIO_N(GPIO_N), .PORT_N(PORT_N)) chk_inst (
	.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
	.reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .gpio_in(gpio_in),
	.egress_stamp_event(egress_stamp_event), .ingress_stamp_event(ingress_stamp_event),
	.time_seconds_out(time_seconds_out), .time_nanoseconds_out(time_nanoseconds_out),
	.time_unit_summary_event(time_unit_summary_event), .irq_out(irq_out)
);

// *** tb_ptp_clock_core_regs.sv ***
// self-checking bench for the precision-time clock core
module tb_ptp_clock_core_regs;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [11:0] addr;
		logic [31:0] wdata;
		logic [31:0] rexp;
	} row_s;
	logic        clk_sys = 1'b0, sys_rst = 1'b1, reg_wr_en = 1'b0, reg_rd_en = 1'b0;
	logic        time_unit_summary_event, irq_out;
	logic [11:0] reg_addr = 12'h000;
	logic [31:0] reg_wr_data = 32'h0000_0000, reg_rd_data, time_seconds_out, v;
	logic [29:0] time_nanoseconds_out;
	logic [7:0]  gpio_in = 8'h00;
	logic [2:0]  egress_stamp_event = 3'b000, ingress_stamp_event = 3'b000;
	int          failures = 0, tests_run = 0;
	row_s        rows [9];

	ptp_clock_core_regs ptp_clock_core_regs_inst (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
		.reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .gpio_in(gpio_in),
		.egress_stamp_event(egress_stamp_event), .ingress_stamp_event(ingress_stamp_event),
		.time_seconds_out(time_seconds_out), .time_nanoseconds_out(time_nanoseconds_out),
		.time_unit_summary_event(time_unit_summary_event), .irq_out(irq_out)
	);

	initial begin
		forever #50 clk_sys = ~clk_sys;
	end

	task automatic summarize();
		if (failures == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr(logic [11:0] a, logic [31:0] d);
		@(posedge clk_sys);
		reg_wr_en   <= 1'b1;
		reg_addr    <= a;
		reg_wr_data <= d;
		@(posedge clk_sys);
		reg_wr_en <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rchk(string name, logic [11:0] a, logic [31:0] exp);
		@(posedge clk_sys);
		reg_rd_en <= 1'b1;
		reg_addr  <= a;
		@(posedge clk_sys);
		reg_rd_en <= 1'b0;
		#1 v = reg_rd_data;
		chk(name, exp, v);
	endtask

	task automatic tchk(logic [29:0] e);
		chk("ns", {2'b00, e}, {2'b00, time_nanoseconds_out});
	endtask

	task automatic wait_irq();
		for (int k = 0; k < 400 && irq_out !== 1'b1; k++) #100;
		chk("irq", 32'h0000_0001, {31'h0, irq_out});
	endtask

	initial begin
		repeat (20000) @(posedge clk_sys);
		failures++;
		summarize();
	end

	initial begin
		rows = '{'{ptp_time_pkg::OFS_IRQ_ENABLE, 32'hFFFF_FFFF, 32'hFFFF_7703},
			'{ptp_time_pkg::OFS_RATE, 32'hFFFF_FFFF, 32'hBFFF_FFFF},
			'{ptp_time_pkg::OFS_SEC, 32'hFFFF_FFFF, 32'hFFFF_FFFF},
			'{ptp_time_pkg::OFS_NS, 32'hFFFF_FFFF, 32'h3FFF_FFFF},
			'{ptp_time_pkg::OFS_SUBNS, 32'hFFFF_FFFF, 32'hFFFF_FFFF},
			'{ptp_time_pkg::OFS_TGT_A_SEC, 32'hFFFF_FFFF, 32'hFFFF_FFFF},
			'{ptp_time_pkg::OFS_GPIO_CLR, 32'hFFFF_FFFF, 32'h0000_1F1F},
			'{ptp_time_pkg::OFS_SYS_ENABLE, 32'hFFFF_FFFF, 32'h0000_0001},
			'{12'h1F0, 32'hFFFF_FFFF, 32'h0000_0000}};
		repeat (12) @(posedge clk_sys);
		sys_rst <= 1'b0;
		foreach (rows[i]) begin
			rchk("reset", rows[i].addr, 32'h0000_0000);
			wr(rows[i].addr, rows[i].wdata);
			rchk("row", rows[i].addr, rows[i].rexp);
		end
		// trimmed step on accumulator wrap, both directions
		for (int d = 0; d < 2; d++) begin
			wr(ptp_time_pkg::OFS_RATE, {d[0], 31'h0000_0010});
			wr(ptp_time_pkg::OFS_NS, 32'h0000_0064);
			wr(ptp_time_pkg::OFS_SUBNS, 32'hFFFF_FFF0);
			wr(ptp_time_pkg::OFS_CMD, 32'h0000_0002);
			#1 tchk(30'd100);
			@(posedge clk_sys);
			#1 tchk(d ? 30'd111 : 30'd109);
			@(posedge clk_sys);
			#1 tchk(d ? 30'd121 : 30'd119);
		end
		wr(ptp_time_pkg::OFS_RATE, 32'h0000_0000);
		wr(ptp_time_pkg::OFS_SEC, 32'h0000_0005);
		wr(ptp_time_pkg::OFS_NS, 32'h3B9A_C9F6);
		wr(ptp_time_pkg::OFS_CMD, 32'h0000_0002);
		#1 chk("sec", 32'h0000_0005, time_seconds_out);
		wr(ptp_time_pkg::OFS_CMD, 32'h0000_0001);
		#1 chk("sec", 32'h0000_0006, time_seconds_out);
		tchk(30'd10);
		rchk("snap sec", ptp_time_pkg::OFS_SEC, 32'h0000_0006);
		rchk("snap ns", ptp_time_pkg::OFS_NS, 32'h0000_0000);
		// compare channels, masking and clearing
		wr(ptp_time_pkg::OFS_IRQ_ENABLE, 32'h0000_0003);
		wr(ptp_time_pkg::OFS_TGT_B_NS, 32'h0000_0FA0);
		wr(ptp_time_pkg::OFS_TGT_B_SEC, 32'h0000_0006);
		wr(ptp_time_pkg::OFS_TGT_A_NS, 32'h0000_07D0);
		wr(ptp_time_pkg::OFS_TGT_A_SEC, 32'h0000_0006);
		wr(ptp_time_pkg::OFS_IRQ_STATUS, 32'hFFFF_FFFF);
		rchk("status", ptp_time_pkg::OFS_IRQ_STATUS, 32'h0000_0000);
		wait_irq();
		rchk("status", ptp_time_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
		wr(ptp_time_pkg::OFS_IRQ_ENABLE, 32'h0000_0002);
		#201 chk("summary", 32'h0000_0000, {31'h0, time_unit_summary_event});
		rchk("status", ptp_time_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
		wait_irq();
		rchk("status", ptp_time_pkg::OFS_IRQ_STATUS, 32'h0000_0003);
		wr(ptp_time_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
		rchk("status", ptp_time_pkg::OFS_IRQ_STATUS, 32'h0000_0002);
		wr(ptp_time_pkg::OFS_IRQ_STATUS, 32'h0000_0000);
		rchk("status", ptp_time_pkg::OFS_IRQ_STATUS, 32'h0000_0002);
		wr(ptp_time_pkg::OFS_SYS_ENABLE, 32'h0000_0000);
		#201 chk("irq", 32'h0000_0000, {31'h0, irq_out});
		chk("summary", 32'h0000_0001, {31'h0, time_unit_summary_event});
		rchk("sys status", ptp_time_pkg::OFS_SYS_STATUS, 32'h0000_0001);
		// stamp events set status with or without enable
		wr(ptp_time_pkg::OFS_IRQ_ENABLE, 32'h0000_2402);
		@(posedge clk_sys);
		egress_stamp_event  <= 3'b010;
		ingress_stamp_event <= 3'b101;
		@(posedge clk_sys);
		egress_stamp_event  <= 3'b000;
		ingress_stamp_event <= 3'b000;
		rchk("status", ptp_time_pkg::OFS_IRQ_STATUS, 32'h0000_2502);
		// rising edge on pin 0 clears timer b
		wr(ptp_time_pkg::OFS_GPIO_CLR, 32'h0000_1000);
		gpio_in <= 8'h01;
		repeat (8) @(posedge clk_sys);
		rchk("status", ptp_time_pkg::OFS_IRQ_STATUS, 32'h0001_2500);
		// re-arm timer a, then a falling edge on pin 0 clears it
		wr(ptp_time_pkg::OFS_TGT_A_SEC, 32'hFFFF_FFFF);
		wr(ptp_time_pkg::OFS_TGT_A_SEC, 32'h0000_0006);
		rchk("status", ptp_time_pkg::OFS_IRQ_STATUS, 32'h0001_2501);
		wr(ptp_time_pkg::OFS_GPIO_CLR, 32'h0000_0018);
		gpio_in <= 8'h00;
		repeat (8) @(posedge clk_sys);
		rchk("status", ptp_time_pkg::OFS_IRQ_STATUS, 32'h0101_2500);
		// reset in mid-run
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		#1 chk("sec", 32'h0000_0000, time_seconds_out);
		tchk(30'd0);
		rchk("enable", ptp_time_pkg::OFS_IRQ_ENABLE, 32'h0000_0000);
		rchk("status", ptp_time_pkg::OFS_IRQ_STATUS, 32'h0000_0003);
		chk("irq", 32'h0000_0000, {31'h0, irq_out});
		chk("summary", 32'h0000_0000, {31'h0, time_unit_summary_event});
		summarize();
	end
endmodule
